// ==== umn_uart.sv ====
// Multinode UART core: transmitter plus receiver with 9-bit address filter.
// Assumes control inputs come from software logic on the same clock; only
// the serial receive line is asynchronous and is synchronised here.
`timescale 1ns/1ns
`default_nettype none
module umn_uart (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    // Configuration
    input  wire logic [15:0] I_BAUD_DIVISOR,
    input  wire logic        I_TX_ENABLE,
    input  wire logic        I_RX_ENABLE,
    input  wire logic        I_PARITY_ENABLE,
    input  wire logic        I_PARITY_ODD,
    input  wire logic        I_MULTINODE_ENABLE,
    input  wire logic [1:0]  I_MULTINODE_FILTER_MODE,
    input  wire logic [7:0]  I_NODE_ADDRESS,
    // Transmit request
    input  wire logic        I_TX_VALID,
    input  wire logic [7:0]  I_TX_DATA,
    input  wire logic        I_TX_ADDRESS,
    output logic             O_TX_READY,
    // Serial lines
    input  wire logic        I_RXD,
    output logic             O_TXD,
    // Receive result
    output logic [7:0]       O_RX_DATA,
    output logic             O_RX_DATA_AVAILABLE,
    output logic             O_RX_INTERRUPT,
    output logic             O_RX_NINTH_BIT_FLAG,
    output logic             O_NEW_FRAME_FLAG,
    output logic             O_FRAMING_ERROR
);
    import umn_pkg::*;

    // Transmit state.
    umn_state_t  tx_st_q, tx_st_d;
    logic [15:0] tx_div_q, tx_div_d;
    logic [3:0]  tx_os_q, tx_os_d;
    logic [3:0]  tx_idx_q, tx_idx_d;
    logic [8:0]  tx_sh_q, tx_sh_d;
    logic        tx_nine_q, tx_nine_d;
    logic        txd_q, txd_d;
    logic        tx_rdy_q, tx_rdy_d;
    logic        tx_tick;

    assign tx_tick = (tx_div_q == 16'h0000);

    always_comb begin
        tx_st_d   = tx_st_q;
        tx_div_d  = tx_tick ? (I_BAUD_DIVISOR - 16'h0001)
                            : tx_div_q - 16'h0001;
        tx_os_d   = tx_os_q;
        tx_idx_d  = tx_idx_q;
        tx_sh_d   = tx_sh_q;
        tx_nine_d = tx_nine_q;
        txd_d     = txd_q;
        tx_rdy_d  = 1'b0;
        if (I_BAUD_DIVISOR == 16'h0000) begin
            tx_div_d = 16'h0000;
        end
        case (tx_st_q)
            UMN_IDLE: begin
                txd_d    = 1'b1;
                tx_rdy_d = I_TX_ENABLE & ~(I_TX_VALID & tx_rdy_q);
                if (I_TX_ENABLE && I_TX_VALID && tx_rdy_q) begin
                    // Ninth bit is address flag, parity, or absent.
                    tx_sh_d   = {1'b0, I_TX_DATA};
                    tx_nine_d = I_MULTINODE_ENABLE | I_PARITY_ENABLE;
                    if (I_MULTINODE_ENABLE) begin
                        tx_sh_d[8] = I_TX_ADDRESS;
                    end else begin
                        tx_sh_d[8] = ^I_TX_DATA ^ I_PARITY_ODD;
                    end
                    tx_st_d  = UMN_START;
                    tx_os_d  = 4'h0;
                    txd_d    = 1'b0;
                end
            end
            UMN_START, UMN_BITS: begin
                if (tx_tick) begin
                    tx_os_d = tx_os_q + 4'h1;
                    if (tx_os_q == 4'hF) begin
                        if (tx_st_q == UMN_START) begin
                            tx_idx_d = 4'h0;
                        end else begin
                            tx_idx_d = tx_idx_q + 4'h1;
                            tx_sh_d  = {1'b0, tx_sh_q[8:1]};
                        end
                        tx_st_d = UMN_BITS;
                        if (tx_st_q == UMN_START) begin
                            txd_d = tx_sh_q[0];
                        end else if (tx_idx_q == 4'(DATA_BITS) - 4'h1 &&
                                     !tx_nine_q) begin
                            txd_d   = 1'b1;
                            tx_st_d = UMN_STOP;
                        end else if (tx_idx_q == 4'(DATA_BITS)) begin
                            txd_d   = 1'b1;
                            tx_st_d = UMN_STOP;
                        end else begin
                            txd_d = tx_sh_q[1];
                        end
                    end
                end
            end
            UMN_STOP: begin
                if (tx_tick) begin
                    tx_os_d = tx_os_q + 4'h1;
                    if (tx_os_q == 4'hF) begin
                        tx_st_d = UMN_IDLE;
                    end
                end
            end
            default: tx_st_d = UMN_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tx_st_q   <= UMN_IDLE;
            tx_div_q  <= 16'h0000;
            tx_os_q   <= 4'h0;
            tx_idx_q  <= 4'h0;
            tx_sh_q   <= 9'h000;
            tx_nine_q <= 1'b0;
            txd_q     <= 1'b1;
            tx_rdy_q  <= 1'b0;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_div_q  <= tx_div_d;
            tx_os_q   <= tx_os_d;
            tx_idx_q  <= tx_idx_d;
            tx_sh_q   <= tx_sh_d;
            tx_nine_q <= tx_nine_d;
            txd_q     <= txd_d;
            tx_rdy_q  <= tx_rdy_d;
        end
    end

    assign O_TXD      = txd_q;
    assign O_TX_READY = tx_rdy_q;

    // Receive line synchroniser; only the second stage is read.
    logic rx_s1_q, rx_s2_q;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= I_RXD;
            rx_s2_q <= rx_s1_q;
        end
    end

    // Receive state and filter state.
    umn_state_t  rx_st_q, rx_st_d;
    logic [15:0] rx_div_q, rx_div_d;
    logic [3:0]  rx_os_q, rx_os_d;
    logic [3:0]  rx_idx_q, rx_idx_d;
    logic [8:0]  rx_sh_q, rx_sh_d;
    logic        rx_nine_q, rx_nine_d;
    logic [7:0]  rdat_q, rdat_d;
    logic        avail_q, avail_d, irq_q, irq_d;
    logic        ninth_q, ninth_d, newf_q, newf_d, ferr_q, ferr_d;
    logic        match_q, match_d, first_q, first_d;
    logic        rx_tick, is_addr, good, pass;

    assign rx_tick = (rx_div_q == 16'h0000);

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_div_d  = rx_tick ? (I_BAUD_DIVISOR - 16'h0001)
                            : rx_div_q - 16'h0001;
        rx_os_d   = rx_os_q;
        rx_idx_d  = rx_idx_q;
        rx_sh_d   = rx_sh_q;
        rx_nine_d = rx_nine_q;
        rdat_d    = rdat_q;
        ninth_d   = ninth_q;
        newf_d    = newf_q;
        ferr_d    = ferr_q;
        match_d   = match_q;
        first_d   = first_q;
        avail_d   = 1'b0;
        irq_d     = 1'b0;
        is_addr   = rx_sh_q[8] & rx_nine_q;
        good      = 1'b0;
        pass      = 1'b0;
        if (I_BAUD_DIVISOR == 16'h0000) begin
            rx_div_d = 16'h0000;
        end
        case (rx_st_q)
            UMN_IDLE: begin
                rx_os_d = 4'h0;
                if (I_RX_ENABLE && !rx_s2_q) begin
                    rx_st_d   = UMN_START;
                    rx_nine_d = I_MULTINODE_ENABLE | I_PARITY_ENABLE;
                end
            end
            UMN_START: begin
                if (rx_tick) begin
                    rx_os_d = rx_os_q + 4'h1;
                    if (rx_os_q == MID_SAMPLE) begin
                        rx_os_d  = 4'h0;
                        rx_idx_d = 4'h0;
                        rx_st_d  = rx_s2_q ? UMN_IDLE : UMN_BITS;
                    end
                end
            end
            UMN_BITS: begin
                if (rx_tick) begin
                    rx_os_d = rx_os_q + 4'h1;
                    if (rx_os_q == 4'hF) begin
                        rx_sh_d  = {rx_s2_q, rx_sh_q[8:1]};
                        rx_idx_d = rx_idx_q + 4'h1;
                        if (rx_idx_q ==
                            4'(DATA_BITS) - 4'h1 + {3'h0, rx_nine_q}) begin
                            rx_st_d = UMN_STOP;
                        end
                    end
                end
            end
            UMN_STOP: begin
                if (rx_tick) begin
                    rx_os_d = rx_os_q + 4'h1;
                    if (rx_os_q == 4'hF) begin
                        rx_st_d = UMN_IDLE;
                        good    = rx_s2_q;
                        ferr_d  = ~rx_s2_q;
                        if (!rx_nine_q) begin
                            rx_sh_d = {1'b0, rx_sh_q[8:1]};
                        end
                    end
                end
            end
            default: rx_st_d = UMN_IDLE;
        endcase

        // Byte completes: apply filter.
        if (good) begin
            is_addr = rx_sh_d[8] & rx_nine_q & I_MULTINODE_ENABLE;
            if (!I_MULTINODE_ENABLE) begin
                pass = 1'b1;
            end else begin
                case (I_MULTINODE_FILTER_MODE)
                    MODE_ALL:  pass = 1'b1;
                    MODE_ADDR: pass = is_addr;
                    MODE_COMPARE: begin
                        if (is_addr) begin
                            // Each address is compared again.
                            match_d = (rx_sh_d[7:0] == I_NODE_ADDRESS);
                            first_d = match_d;
                            pass    = match_d;
                        end else begin
                            pass = match_q;
                        end
                    end
                    MODE_DATA: begin
                        if (is_addr) begin
                            match_d = (rx_sh_d[7:0] == I_NODE_ADDRESS);
                            first_d = match_d;
                        end else begin
                            pass = match_q;
                        end
                    end
                    default: pass = 1'b0;
                endcase
            end
            if (pass) begin
                rdat_d  = rx_sh_d[7:0];
                avail_d = 1'b1;
                irq_d   = 1'b1;
                ninth_d = is_addr;
                newf_d  = first_q & ~is_addr &
                          I_MULTINODE_FILTER_MODE[1];
                if (!is_addr) begin
                    first_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rx_st_q   <= UMN_IDLE;
            rx_div_q  <= 16'h0000;
            rx_os_q   <= 4'h0;
            rx_idx_q  <= 4'h0;
            rx_sh_q   <= 9'h000;
            rx_nine_q <= 1'b0;
            rdat_q    <= 8'h00;
            avail_q   <= 1'b0;
            irq_q     <= 1'b0;
            ninth_q   <= 1'b0;
            newf_q    <= 1'b0;
            ferr_q    <= 1'b0;
            match_q   <= 1'b0;
            first_q   <= 1'b0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_div_q  <= rx_div_d;
            rx_os_q   <= rx_os_d;
            rx_idx_q  <= rx_idx_d;
            rx_sh_q   <= rx_sh_d;
            rx_nine_q <= rx_nine_d;
            rdat_q    <= rdat_d;
            avail_q   <= avail_d;
            irq_q     <= irq_d;
            ninth_q   <= ninth_d;
            newf_q    <= newf_d;
            ferr_q    <= ferr_d;
            match_q   <= match_d;
            first_q   <= first_d;
        end
    end

    assign O_RX_DATA           = rdat_q;
    assign O_RX_DATA_AVAILABLE = avail_q;
    assign O_RX_INTERRUPT      = irq_q;
    assign O_RX_NINTH_BIT_FLAG = ninth_q;
    assign O_NEW_FRAME_FLAG    = newf_q;
    assign O_FRAMING_ERROR     = ferr_q;

    // Checks.
    tx_idle_high_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN) !I_TX_ENABLE && tx_st_q == UMN_IDLE
        |=> O_TXD && !O_TX_READY)
        else $error("transmit started while disabled");
    tx_start_low_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        tx_st_q == UMN_IDLE && I_TX_VALID && O_TX_READY && I_TX_ENABLE
        |=> !O_TXD && tx_st_q == UMN_START)
        else $error("no start bit");
    addr_mode_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        $past(I_MULTINODE_ENABLE) && $past(I_MULTINODE_FILTER_MODE) ==
        MODE_ADDR && O_RX_INTERRUPT |-> O_RX_NINTH_BIT_FLAG)
        else $error("data byte interrupted in address mode");
    data_mode_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        $past(I_MULTINODE_ENABLE) && $past(I_MULTINODE_FILTER_MODE) ==
        MODE_DATA && O_RX_INTERRUPT |-> !O_RX_NINTH_BIT_FLAG)
        else $error("address byte interrupted in data mode");
    cmp_addr_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        $past(I_MULTINODE_ENABLE) && $past(I_MULTINODE_FILTER_MODE) ==
        MODE_COMPARE && O_RX_INTERRUPT && O_RX_NINTH_BIT_FLAG
        |-> O_RX_DATA == $past(I_NODE_ADDRESS))
        else $error("mismatched address passed");
    cmp_data_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        O_RX_INTERRUPT && !O_RX_NINTH_BIT_FLAG && $past(I_MULTINODE_ENABLE)
        && $past(I_MULTINODE_FILTER_MODE) == MODE_COMPARE |-> match_q)
        else $error("data of foreign frame passed");
    newf_only_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        O_NEW_FRAME_FLAG |-> !O_RX_NINTH_BIT_FLAG)
        else $error("new frame flag on address byte");
    irq_avail_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        O_RX_INTERRUPT == O_RX_DATA_AVAILABLE)
        else $error("interrupt and data flag differ");
    pulse_one_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        O_RX_INTERRUPT |=> !O_RX_INTERRUPT)
        else $error("receive pulse longer than one cycle");
    // The flag is a level that outlives a mode change, so only the
    // cycle that delivers the byte is held against the enable.
    addr_ninth_a: assert property (@(posedge I_CLK)
        disable iff (!I_RSTN)
        O_RX_INTERRUPT && O_RX_NINTH_BIT_FLAG |-> $past(I_MULTINODE_ENABLE))
        else $error("address flag without multinode");
    rx_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_RX_INTERRUPT && O_NEW_FRAME_FLAG);
    tx_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        tx_st_q == UMN_STOP ##1 tx_st_q == UMN_IDLE);
    addr_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_RX_INTERRUPT && O_RX_NINTH_BIT_FLAG);
endmodule : umn_uart
`default_nettype wire

// ==== umn_pkg.sv ====
// Package for the multinode UART: mode codes, frame layout and timing.
// Assumes a single system clock shared by every user of these constants.
package umn_pkg;
    localparam logic [1:0]  MODE_ALL      = 2'h0;
    localparam logic [1:0]  MODE_ADDR     = 2'h1;
    localparam logic [1:0]  MODE_COMPARE  = 2'h2;
    localparam logic [1:0]  MODE_DATA     = 2'h3;
    localparam int          DATA_BITS     = 8;
    localparam logic [4:0]  OVERSAMPLE    = 5'h10;
    localparam logic [3:0]  MID_SAMPLE    = 4'h7;
    localparam logic [15:0] DIVISOR_RESET = 16'h0101;
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam int          CLK_HZ        = 25000000;

    typedef enum logic [1:0] {
        UMN_IDLE  = 2'b00,
        UMN_START = 2'b01,
        UMN_BITS  = 2'b10,
        UMN_STOP  = 2'b11
    } umn_state_t;
endpackage : umn_pkg

// ==== umn_node_model.sv ====
// Far node on the multinode line: sends frames and decodes our output.
// Assumes it shares the design clock and follows the design's divisor.
`timescale 1ns/1ns
`default_nettype none
module umn_node_model (
    // Clock and line settings
    input  wire logic        clk,
    input  wire logic [15:0] div,
    input  wire logic        ninth_on,
    // Serial lines
    input  wire logic        txd_in,
    output logic             rxd_out
);
    logic [8:0] rx_q[$];
    logic [8:0] sh;
    int         k;

    // The line rests high between frames, as a pulled-up line would.
    initial rxd_out = 1'b1;

    // A low stop bit is sent only when a scenario asks for it.
    task automatic send(input logic [7:0] b, input logic n9,
                        input logic has9, input logic stop);
        logic [10:0] f;
        int          nb;
        f  = has9 ? {stop, n9, b, 1'b0} : {1'b1, stop, b, 1'b0};
        nb = has9 ? 11 : 10;
        for (int i = 0; i < nb; i++) begin
            rxd_out = f[i];
            repeat (16 * div) @(negedge clk);
        end
        rxd_out = 1'b1;
    endtask : send

    // Each bit is sampled at its middle, sixteen ticks apart.
    always begin : decode
        @(negedge txd_in);
        repeat (8 * div) @(posedge clk);
        for (k = 0; k < 9; k++) begin
            if (k < 8 || ninth_on) begin
                repeat (16 * div) @(posedge clk);
                sh[k] = txd_in;
            end else begin
                sh[k] = 1'b0;
            end
        end
        repeat (16 * div) @(posedge clk);
        if (txd_in === 1'b1) begin
            rx_q.push_back(sh);
        end
    end
endmodule : umn_node_model
`default_nettype wire

// ==== uart_multinode_addressing_tb.sv ====
// Self-checking bench for the multinode UART core.
// Assumes umn_pkg, umn_uart and umn_node_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module uart_multinode_addressing_tb;
    import umn_pkg::*;
    logic        clk, rstn, tx_en, par_en, par_odd, mn_en;
    logic        tx_valid, tx_addr, rxd, txd, tx_ready;
    logic        rx_avail, rx_int, rx_ninth, new_frame, frame_err;
    logic        rx_en, got_ninth, got_nf, matched, first_data;
    logic [15:0] div;
    logic [1:0]  mode, grp_mode;
    logic [7:0]  node_addr, tx_data, rx_data, got_data;
    logic [8:0]  seen;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;
    int          pulses = 0;
    int          seed = 32'h9ffa;

    umn_uart uut (
        .I_CLK(clk), .I_RSTN(rstn), .I_BAUD_DIVISOR(div),
        .I_TX_ENABLE(tx_en), .I_RX_ENABLE(rx_en),
        .I_PARITY_ENABLE(par_en), .I_PARITY_ODD(par_odd),
        .I_MULTINODE_ENABLE(mn_en), .I_MULTINODE_FILTER_MODE(mode),
        .I_NODE_ADDRESS(node_addr), .I_TX_VALID(tx_valid),
        .I_TX_DATA(tx_data), .I_TX_ADDRESS(tx_addr),
        .O_TX_READY(tx_ready), .I_RXD(rxd), .O_TXD(txd),
        .O_RX_DATA(rx_data), .O_RX_DATA_AVAILABLE(rx_avail),
        .O_RX_INTERRUPT(rx_int), .O_RX_NINTH_BIT_FLAG(rx_ninth),
        .O_NEW_FRAME_FLAG(new_frame), .O_FRAMING_ERROR(frame_err)
    );

    umn_node_model node (
        .clk(clk), .div(div), .ninth_on(mn_en | par_en),
        .txd_in(txd), .rxd_out(rxd)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The planned traffic needs about 35000 cycles; this leaves margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [8:0] exp,
                         input logic [8:0] act);
        compares++;
        if (exp !== act) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, act);
        end
    endtask : check

    task automatic complete_run();
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Pulses last one cycle; they are counted and latched mid-cycle,
    // where the registered outputs are settled.
    always @(negedge clk) begin
        if (rx_avail === 1'b1 || rx_int === 1'b1) begin
            check("rx irq", {8'h00, rx_avail}, {8'h00, rx_int});
            pulses++;
            got_data = rx_data;
            got_ninth = rx_ninth;
            got_nf = new_frame;
        end
    end

    function automatic logic exp_pass(input logic [1:0] m, input logic mn,
                                      input logic a, input logic mt);
        if (!mn) return 1'b1;
        case (m)
            MODE_ALL:     return 1'b1;
            MODE_ADDR:    return a;
            MODE_COMPARE: return mt;
            default:      return !a && mt;
        endcase
    endfunction : exp_pass

    task automatic step(input logic [1:0] m, input logic a,
                        input logic [7:0] b, input logic stop);
        logic pass, nf;
        int   p0;
        mode = m;
        if (a && mn_en && m[1]) begin
            matched = (b === node_addr);
            first_data = matched;
        end
        pass = rx_en && stop && exp_pass(m, mn_en, a, matched);
        nf = !a && first_data;
        if (pass && !a) first_data = 1'b0;
        p0 = pulses;
        node.send(b, a, mn_en, stop);
        repeat (32 * div) @(negedge clk);
        check("rx pulse", {8'h00, pass}, 9'(pulses - p0));
        check("framing", {8'h00, !stop}, {8'h00, frame_err});
        if (pass && pulses != p0) begin
            check("rx data", {1'b0, b}, {1'b0, got_data});
            if (mn_en) begin
                check("ninth", {8'h00, a}, {8'h00, got_ninth});
            end
            if (mn_en && m[1] && !a) begin
                check("new frame", {8'h00, nf}, {8'h00, got_nf});
            end
        end
    endtask : step

    task automatic tx_send(input logic [7:0] b, input logic a);
        logic [8:0] exp;
        int         n;
        exp = {mn_en ? a : (par_en && (^b ^ par_odd)), b};
        tx_data = b;
        tx_addr = a;
        tx_valid = 1'b1;
        // Ready is looked at mid-cycle; the next rising edge takes the byte.
        n = 0;
        while (tx_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
        n = 0;
        while (node.rx_q.size() == 0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        seen = (node.rx_q.size() > 0) ? node.rx_q.pop_front() : 'x;
        check("tx frame", exp, seen);
    endtask : tx_send

    initial begin
        rstn = 1'b0;
        {tx_en, par_en, par_odd, mn_en, tx_valid, tx_addr} = 6'h00;
        {matched, first_data} = 2'h0;
        rx_en = 1'b1;
        mode = MODE_ALL;
        div = 16'h0003;
        node_addr = 8'h00;
        tx_data = 8'h00;
        repeat (10) @(negedge clk);
        check("txd reset", 9'h001, {8'h00, txd});
        rstn = 1'b1;
        tx_valid = 1'b1;
        repeat (600) @(negedge clk);
        check("tx quiet", 9'h000, 9'(node.rx_q.size()));
        check("ready off", 9'h000, {8'h00, tx_ready});
        // Divisor first, then mode, then enable; parity only without it.
        for (int i = 0; i < 4; i++) begin
            par_en = (i == 1 || i == 2);
            par_odd = (i == 2);
            mn_en = (i == 3);
            tx_en = 1'b1;
            repeat (4) begin
                tx_send(8'($random(seed)), 1'($random(seed)));
            end
        end
        tx_en = 1'b0;
        div = 16'h0002;
        node_addr = 8'($random(seed));
        step(MODE_ADDR, 1'b0, 8'h5A, 1'b1);
        step(MODE_ADDR, 1'b1, node_addr, 1'b1);
        step(MODE_ALL, 1'b0, 8'hA5, 1'b1);
        step(MODE_ALL, 1'b1, ~node_addr, 1'b1);
        step(MODE_ADDR, 1'b0, 8'h3C, 1'b1);
        step(MODE_COMPARE, 1'b1, ~node_addr, 1'b1);
        step(MODE_COMPARE, 1'b0, 8'h11, 1'b1);
        step(MODE_COMPARE, 1'b1, node_addr, 1'b1);
        step(MODE_COMPARE, 1'b0, 8'h22, 1'b1);
        step(MODE_COMPARE, 1'b0, 8'h33, 1'b1);
        step(MODE_COMPARE, 1'b1, node_addr, 1'b1);
        step(MODE_COMPARE, 1'b0, 8'h44, 1'b1);
        step(MODE_DATA, 1'b1, node_addr, 1'b1);
        step(MODE_DATA, 1'b0, 8'h55, 1'b1);
        step(MODE_DATA, 1'b1, ~node_addr, 1'b1);
        step(MODE_DATA, 1'b0, 8'h66, 1'b1);
        step(MODE_ALL, 1'b0, 8'h77, 1'b0);
        mn_en = 1'b0;
        step(MODE_ADDR, 1'b0, 8'h88, 1'b1);
        // A disabled receiver must let a whole frame go by unseen.
        rx_en = 1'b0;
        step(MODE_ALL, 1'b0, 8'h99, 1'b1);
        rx_en = 1'b1;
        mn_en = 1'b1;
        for (int g = 0; g < 5; g++) begin
            grp_mode = 2'($random(seed));
            for (int j = 0; j < 8; j++) begin
                step(grp_mode, (j == 0) || 1'($random(seed)),
                     1'($random(seed)) ? node_addr : 8'($random(seed)), 1'b1);
            end
        end
        complete_run();
    end
endmodule : uart_multinode_addressing_tb
`default_nettype wire
